// file: logic/wfs_pkg.sv
/*
 * Shared constants and types of the waveform function sequencer.
 * Assumes a single 20 MHz system clock; all times are counted in 0.1 ms ticks.
 */
package wfs_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_S = 1000000000 / TICK_NS;
  localparam int T_MAX_MS = 36000000;
  localparam int T_MAX_TICKS = T_MAX_MS * (1000000 / TICK_NS); // Ordered so the product fits 32 bits
  localparam int T_MIN_TICKS = 1;
  localparam int FREQ_MAX_HZ = 10000;
  // Phase increment per tick for 1 Hz on a 32-bit accumulator
  localparam longint PHASE_INC_HZ = 64'h0000_0001_0000_0000 / TICKS_PER_S;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int VAL_W = 16;
  localparam int T_W = 29;
  localparam int F_W = 14;
  localparam int ACC_W = 32;
  localparam int NSYNC = 2;
  localparam int SYNC_BTN = 0;
  localparam int SYNC_ALM = 1;
  localparam logic [VAL_W-1:0] SINK_CUR_RST = 16'h0000;
  localparam logic [VAL_W-1:0] NOM_DEF = 16'h7fff;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    WFS_SINE = 2'h0,
    WFS_TRI = 2'h1,
    WFS_RECT = 2'h2,
    WFS_TRAP = 2'h3
  } wfs_kind_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CFG = 4'h2,
    ST_READY = 4'h4,
    ST_RUN = 4'h8
  } wfs_state_e;
endpackage

// file: logic/wfs_sequencer.sv
/*
 * Function generator sequencer: configuration lock, start/stop, alarm abort,
 * static setpoints and routing of the waveform to the voltage or current setpoint.
 * Assumes one 20 MHz clock; the front button and external alarm are asynchronous
 * pins, every other input comes from logic on the same clock.
 */
`timescale 1ns/1ns
// Overview of operation
// - Refuse configuration in resistance mode; select functions only while output off.
// - Controller picks voltage or current target; waveform drives that one only.
// - Static voltage, current, power setpoints apply before and after a run.
// - Leaving configuration switches output on with global limits active at once.
// - Parameter updates are taken before and during a run without stopping it.
// - Start on touch command, or front button while output is off.
// - Touch stop halts the waveform, output stays on with static setpoints.
// - Front button during a run halts the waveform and switches output off.
// - Alarm, overpower or overcurrent trip, alarm event: abort, output off, report.
// - No source or sink preselection; setpoints alone decide direction.
// - Voltage target: sink only if external voltage above peak and sink current nonzero.
// - Sine runs at one fixed frequency up to 10000 Hz.
// - Sine offset from zero point; amplitude limited to rated minus offset magnitude.
// - Triangle rises over t1 from offset to peak, falls over t2.
// - Rectangle holds offset plus amplitude for pulse time t1.
// - Rectangle then holds the offset for pause time t2 and repeats.
// - Trapezoid: rise t1, top t2, fall t3, base t4, then repeat.
// - Voltage offset 0..nominal minus amplitude; current offset symmetric within that.
// - Selecting a function clears the sink current setpoint to zero.
// - Only one setpoint is modulated; the other two stay constant as limits.
module wfs_sequencer #(
  parameter logic [wfs_pkg::VAL_W-1:0] U_NOM = wfs_pkg::NOM_DEF,
  parameter logic [wfs_pkg::VAL_W-1:0] I_NOM = wfs_pkg::NOM_DEF
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Operator and remote commands, one-cycle pulses except the front button pin
  input wire logic resist_mode_i,
  input wire logic cfg_enter_i,
  input wire logic func_sel_i,
  input wire logic [1:0] func_kind_i,
  input wire logic target_cur_i,
  input wire logic cfg_exit_i,
  input wire logic gen_quit_i,
  input wire logic start_touch_i,
  input wire logic stop_touch_i,
  input wire logic onoff_btn_i,
  // Protection sources
  input wire logic dev_alarm_i,
  input wire logic overpower_protection_i,
  input wire logic overcurrent_protection_i,
  input wire logic event_alarm_i,
  input wire logic alarm_ack_i,
  // Waveform parameters, live
  input wire logic [wfs_pkg::VAL_W-1:0] amp_i,
  input wire logic signed [wfs_pkg::VAL_W-1:0] offset_i,
  input wire logic [wfs_pkg::F_W-1:0] freq_i,
  input wire logic [wfs_pkg::T_W-1:0] t1_i,
  input wire logic [wfs_pkg::T_W-1:0] t2_i,
  input wire logic [wfs_pkg::T_W-1:0] t3_i,
  input wire logic [wfs_pkg::T_W-1:0] t4_i,
  // Static global setpoints, live
  input wire logic [wfs_pkg::VAL_W-1:0] static_u_i,
  input wire logic [wfs_pkg::VAL_W-1:0] static_i_i,
  input wire logic [wfs_pkg::VAL_W-1:0] static_p_i,
  input wire logic sink_cur_wr_i,
  input wire logic [wfs_pkg::VAL_W-1:0] sink_cur_i,
  input wire logic [wfs_pkg::VAL_W-1:0] ext_volt_i,
  // Power stage and status
  output logic dc_on_o,
  output logic signed [wfs_pkg::VAL_W-1:0] set_u_o,
  output logic signed [wfs_pkg::VAL_W-1:0] set_i_o,
  output logic [wfs_pkg::VAL_W-1:0] set_p_o,
  output logic [wfs_pkg::VAL_W-1:0] sink_current_setpoint_o,
  output logic sink_en_o,
  output logic cfg_active_o,
  output logic gen_view_o,
  output logic running_o,
  output logic cfg_refused_o,
  output logic alarm_o
);
  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Three stages; a change is accepted once stages two and three agree
  localparam int NSYNC_L = wfs_pkg::NSYNC;
  logic [NSYNC_L-1:0] s1_q, s2_q, s3_q, pin_q;
  wire [NSYNC_L-1:0] pin_raw = {dev_alarm_i, onoff_btn_i};
  genvar g;
  generate
    for (g = 0; g < NSYNC_L; g++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          pin_q[g] <= (s2_q[g] == s3_q[g]) ? s3_q[g] : pin_q[g];
        end
      end
    end
  endgenerate

  // Button press counts once on its accepted rising edge
  logic btn_prev_q;
  wire btn_press = pin_q[wfs_pkg::SYNC_BTN] & ~btn_prev_q;
  wire alarm_any = pin_q[wfs_pkg::SYNC_ALM] | overpower_protection_i
    | overcurrent_protection_i | event_alarm_i;

  // ==========================================================================
  // 0.1 ms tick
  // ==========================================================================
  localparam logic [11:0] TICK_LAST = 12'(wfs_pkg::TICK_CYC - 1);
  logic [11:0] tick_cnt_q;
  wire tick = (tick_cnt_q == TICK_LAST);

  // ==========================================================================
  // Parameter clamping
  // ==========================================================================
  // Amplitude first bounded by rated value minus offset magnitude, then the
  // offset is pulled into the window that amplitude leaves
  logic target_cur_q;
  wire [wfs_pkg::VAL_W-1:0] nom = target_cur_q ? I_NOM : U_NOM;
  wire [wfs_pkg::VAL_W-1:0] off_abs = offset_i[wfs_pkg::VAL_W-1] ? -offset_i : offset_i;
  wire [wfs_pkg::VAL_W-1:0] off_mag = (off_abs > nom) ? nom : off_abs;
  wire [wfs_pkg::VAL_W-1:0] amp_room = nom - off_mag;
  wire [wfs_pkg::VAL_W-1:0] amp_c = (amp_i > amp_room) ? amp_room : amp_i;
  wire signed [wfs_pkg::VAL_W:0] off_hi = {1'b0, nom - amp_c};
  wire signed [wfs_pkg::VAL_W:0] off_lo = target_cur_q ? -off_hi : '0;
  wire signed [wfs_pkg::VAL_W:0] off_x = offset_i;
  wire signed [wfs_pkg::VAL_W:0] off_c = (off_x > off_hi) ? off_hi : (off_x < off_lo) ? off_lo : off_x;
  wire [wfs_pkg::F_W-1:0] freq_c = (freq_i > wfs_pkg::F_W'(wfs_pkg::FREQ_MAX_HZ)) ?
    wfs_pkg::F_W'(wfs_pkg::FREQ_MAX_HZ) : freq_i;

  // ==========================================================================
  // Control state
  // ==========================================================================
  wfs_pkg::wfs_state_e state_q, state_d;
  wfs_pkg::wfs_kind_e kind_q;
  logic dc_on_q, dc_on_d;
  logic alarm_q;
  logic refused_q;
  logic [wfs_pkg::VAL_W-1:0] sink_cur_q;

  wire st_idle = (state_q == wfs_pkg::ST_IDLE);
  wire st_cfg = (state_q == wfs_pkg::ST_CFG);
  wire st_ready = (state_q == wfs_pkg::ST_READY);
  wire st_run = (state_q == wfs_pkg::ST_RUN);
  wire enter_ok = st_idle & cfg_enter_i & ~resist_mode_i & ~dc_on_q;
  wire sel_ok = st_cfg & func_sel_i & ~dc_on_q;
  wire start_go = st_ready & ~alarm_any & (start_touch_i | (btn_press & ~dc_on_q));

  // Next state; alarm abort takes priority over every command except a configuration entry from idle and a generator quit from ready
  always_comb begin
    state_d = state_q;
    dc_on_d = dc_on_q;
    case (state_q)
      wfs_pkg::ST_IDLE: begin
        if (enter_ok) begin
          state_d = wfs_pkg::ST_CFG;
        end
      end
      wfs_pkg::ST_CFG: begin
        if (cfg_exit_i) begin
          state_d = wfs_pkg::ST_READY;
          dc_on_d = 1'b1;
        end
      end
      wfs_pkg::ST_READY: begin
        if (start_go) begin
          state_d = wfs_pkg::ST_RUN;
          dc_on_d = 1'b1;
        end else if (btn_press && dc_on_q) begin
          dc_on_d = 1'b0;
        end else if (gen_quit_i && !dc_on_q) begin
          state_d = wfs_pkg::ST_IDLE;
        end
      end
      wfs_pkg::ST_RUN: begin
        if (btn_press) begin
          state_d = wfs_pkg::ST_READY;
          dc_on_d = 1'b0;
        end else if (stop_touch_i) begin
          state_d = wfs_pkg::ST_READY;
        end
      end
      default: begin
        state_d = wfs_pkg::ST_IDLE;
        dc_on_d = 1'b0;
      end
    endcase
    if (alarm_any) begin
      dc_on_d = 1'b0;
      if (st_run || st_cfg) begin
        state_d = st_run ? wfs_pkg::ST_READY : wfs_pkg::ST_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= wfs_pkg::ST_IDLE;
      dc_on_q <= 1'b0;
      btn_prev_q <= 1'b0;
      tick_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      dc_on_q <= dc_on_d;
      btn_prev_q <= pin_q[wfs_pkg::SYNC_BTN];
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 12'h001;
    end
  end

  // Function choice latched only on an accepted selection
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      kind_q <= wfs_pkg::WFS_SINE;
      target_cur_q <= 1'b0;
    end else if (sel_ok) begin
      kind_q <= wfs_pkg::wfs_kind_e'(func_kind_i);
      target_cur_q <= target_cur_i;
    end
  end

  // Sink current: selection clearing beats a same-cycle write for safety
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sink_cur_q <= wfs_pkg::SINK_CUR_RST;
    end else if (sel_ok) begin
      sink_cur_q <= '0;
    end else if (sink_cur_wr_i) begin
      sink_cur_q <= sink_cur_i;
    end
  end

  // Sticky alarm report; a new trip wins over the acknowledge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      alarm_q <= alarm_any | (alarm_q & ~alarm_ack_i);
      refused_q <= st_idle & cfg_enter_i & (resist_mode_i | dc_on_q);
    end
  end

  // ==========================================================================
  // Waveform engine
  // ==========================================================================
  wfs_wave_if wv ();
  assign wv.run = st_run;
  assign wv.tick = tick;
  assign wv.kind = kind_q;
  assign wv.amp = amp_c;
  assign wv.off = wfs_pkg::VAL_W'(off_c);
  assign wv.freq = freq_c;
  assign wv.t[0] = t1_i;
  assign wv.t[1] = t2_i;
  assign wv.t[2] = t3_i;
  assign wv.t[3] = t4_i;

  wfs_wave_engine u_engine (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .w(wv.eng)
  );

  // ==========================================================================
  // Setpoint routing
  // ==========================================================================
  // Only the chosen target follows the wave; the rest stay as limits
  wire drive_u = st_run & ~target_cur_q;
  wire drive_i = st_run & target_cur_q;
  wire [wfs_pkg::VAL_W:0] peak = wfs_pkg::VAL_W'(off_c) + amp_c;
  // Direction is never forced; it follows the setpoints alone
  wire sink_ok = (sink_cur_q != '0) & dc_on_q
    & (target_cur_q | ({1'b0, ext_volt_i} > peak));
  logic signed [wfs_pkg::VAL_W-1:0] set_u_q, set_i_q;
  logic [wfs_pkg::VAL_W-1:0] set_p_q;
  logic sink_en_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      set_u_q <= '0;
      set_i_q <= '0;
      set_p_q <= '0;
      sink_en_q <= 1'b0;
    end else begin
      set_u_q <= drive_u ? wv.value : static_u_i;
      set_i_q <= drive_i ? wv.value : static_i_i;
      set_p_q <= static_p_i;
      sink_en_q <= sink_ok;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign dc_on_o = dc_on_q;
  assign set_u_o = set_u_q;
  assign set_i_o = set_i_q;
  assign set_p_o = set_p_q;
  assign sink_current_setpoint_o = sink_cur_q;
  assign sink_en_o = sink_en_q;
  assign cfg_active_o = st_cfg;
  assign gen_view_o = st_ready | st_run;
  assign running_o = st_run;
  assign cfg_refused_o = refused_q;
  assign alarm_o = alarm_q;
endmodule // wfs_sequencer

// file: logic/wfs_wave_engine.sv
/*
 * Waveform engine: sine, triangle, rectangle and trapezoid per 0.1 ms tick.
 * Assumes amplitude and offset arrive already clamped to the rated range.
 */
`timescale 1ns/1ns
module wfs_wave_engine (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  wfs_wave_if.eng w
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Quarter sine, 16 steps, magnitude scaled to 255
  function automatic logic signed [9:0] wfs_sin(input logic [5:0] ph);
    logic [3:0] i;
    logic [7:0] m;
    i = ph[4] ? ~ph[3:0] : ph[3:0];
    case (i)
      4'h0: m = 8'h0c; 4'h1: m = 8'h25; 4'h2: m = 8'h3e; 4'h3: m = 8'h56;
      4'h4: m = 8'h6d; 4'h5: m = 8'h83; 4'h6: m = 8'h98; 4'h7: m = 8'hab;
      4'h8: m = 8'hbc; 4'h9: m = 8'hcb; 4'ha: m = 8'hd8; 4'hb: m = 8'he3;
      4'hc: m = 8'hec; 4'hd: m = 8'hf3; 4'he: m = 8'hf8; default: m = 8'hfe;
    endcase
    wfs_sin = ph[5] ? -$signed({2'h0, m}) : $signed({2'h0, m});
  endfunction

  // ==========================================================================
  // Phase times clipped to 0.1 ms .. 36,000,000 ms
  // ==========================================================================
  logic [wfs_pkg::T_W-1:0] t_c [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tclip
      assign t_c[g] = (w.t[g] < wfs_pkg::T_W'(wfs_pkg::T_MIN_TICKS)) ? wfs_pkg::T_W'(wfs_pkg::T_MIN_TICKS) :
        (w.t[g] > wfs_pkg::T_W'(wfs_pkg::T_MAX_TICKS)) ? wfs_pkg::T_W'(wfs_pkg::T_MAX_TICKS) : w.t[g];
    end
  endgenerate

  logic [1:0] phase_q, phase_d;
  logic [wfs_pkg::T_W-1:0] cnt_q, cnt_d;
  logic [wfs_pkg::ACC_W-1:0] acc_q, acc_d;
  logic signed [wfs_pkg::VAL_W-1:0] val_q, val_d;

  // ==========================================================================
  // Phase sequencing
  // ==========================================================================
  wire [wfs_pkg::T_W-1:0] t_cur = t_c[phase_q];
  wire phase_end = (cnt_q + 1'b1) >= t_cur;
  wire [1:0] last_ph = (w.kind == wfs_pkg::WFS_TRAP) ? 2'h3 : 2'h1;
  wire [1:0] next_ph = (phase_q == last_ph) ? 2'h0 : phase_q + 2'h1;
  wire [wfs_pkg::ACC_W-1:0] inc = wfs_pkg::ACC_W'(w.freq * wfs_pkg::PHASE_INC_HZ);
  // Stopped engine stays cleared so a new start opens with the first phase
  assign cnt_d = !w.run ? '0 : !w.tick ? cnt_q : phase_end ? '0 : cnt_q + 1'b1;
  assign phase_d = !w.run ? 2'h0 : (w.tick && phase_end) ? next_ph : phase_q;
  assign acc_d = !w.run ? '0 : w.tick ? acc_q + inc : acc_q;

  // ==========================================================================
  // Level of the current phase
  // ==========================================================================
  wire [wfs_pkg::VAL_W+wfs_pkg::T_W-1:0] ramp_num = $unsigned(w.amp) * cnt_q;
  wire signed [wfs_pkg::VAL_W+1:0] ramp = $signed({2'h0, wfs_pkg::VAL_W'(ramp_num / t_cur)});
  wire signed [wfs_pkg::VAL_W+1:0] base = w.off;
  wire signed [wfs_pkg::VAL_W+1:0] top = base + w.amp;
  wire signed [wfs_pkg::VAL_W+9:0] sprod = w.amp * wfs_sin(acc_q[31:26]);
  wire signed [wfs_pkg::VAL_W+1:0] sine = base + (wfs_pkg::VAL_W+2)'(sprod >>> 8);
  logic signed [wfs_pkg::VAL_W+1:0] lvl;
  always_comb begin
    case (w.kind)
      wfs_pkg::WFS_SINE: lvl = sine;
      wfs_pkg::WFS_TRI: lvl = (phase_q == 2'h0) ? base + ramp : top - ramp;
      wfs_pkg::WFS_RECT: lvl = (phase_q == 2'h0) ? top : base;
      default: begin
        case (phase_q)
          2'h0: lvl = base + ramp;
          2'h1: lvl = top;
          2'h2: lvl = top - ramp;
          default: lvl = base;
        endcase
      end
    endcase
  end
  // Refresh only on ticks; idle engine shows the offset base
  assign val_d = !w.run ? w.off : w.tick ? wfs_pkg::VAL_W'(lvl) : val_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= 2'h0;
      cnt_q <= '0;
      acc_q <= '0;
      val_q <= '0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      val_q <= val_d;
    end
  end
  assign w.value = val_q;
endmodule // wfs_wave_engine

// file: logic/wfs_wave_if.sv
/*
 * Carrier between the sequencer and its waveform engine.
 * Assumes both ends sit on the same system clock.
 */
`timescale 1ns/1ns
interface wfs_wave_if;
  logic run;
  logic tick;
  wfs_pkg::wfs_kind_e kind;
  logic signed [wfs_pkg::VAL_W-1:0] amp;
  logic signed [wfs_pkg::VAL_W-1:0] off;
  logic [wfs_pkg::F_W-1:0] freq;
  logic [wfs_pkg::T_W-1:0] t [4];
  logic signed [wfs_pkg::VAL_W-1:0] value;

  modport ctl (output run, output tick, output kind, output amp, output off, output freq, output t,
    input value);
  modport eng (input run, input tick, input kind, input amp, input off, input freq, input t,
    output value);
endinterface

// file: test/tb_waveform_function_sequencer.sv
/* Self-checking bench for wfs_sequencer with a power stage stand-in.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ns
module tb_waveform_function_sequencer;
  typedef struct {int s; logic [15:0] v;} wfs_note_s;
  // ==========
  // Signals
  // ==========
  logic sys_clk_i = 1'b0;
  logic nrst_i, resist_mode_i, cfg_enter_i, func_sel_i, target_cur_i, cfg_exit_i, gen_quit_i;
  logic start_touch_i, stop_touch_i, onoff_btn_i, dev_alarm_i, overpower_protection_i;
  logic event_alarm_i, alarm_ack_i, sink_cur_wr_i, trip_req;
  logic [1:0] func_kind_i;
  logic [15:0] amp_i, offset_i, static_u_i, static_i_i, static_p_i, sink_cur_i;
  logic [13:0] freq_i;
  logic [28:0] t1_i, t2_i, t3_i, t4_i;
  wire logic overcurrent_protection_i, dc_on_o, sink_en_o, cfg_active_o, gen_view_o;
  wire logic running_o, cfg_refused_o, alarm_o;
  wire logic [15:0] ext_volt_i, set_u_o, set_i_o, set_p_o, sink_current_setpoint_o;
  wire logic [5:0] flags = {alarm_o, cfg_refused_o, cfg_active_o, gen_view_o, running_o, dc_on_o};
  wfs_note_s q[$];
  wfs_note_s n;
  int errors = 0, tests_run = 0, cycles = 0, seed = 30095, top = 0, bas = 0, bad = 0;

  wfs_sequencer dut (.*);
  wfs_stage_model stage (.sys_clk_i, .dc_on_i(dc_on_o), .set_u_i(set_u_o), .trip_req_i(trip_req),
    .ext_volt_o(ext_volt_i), .ocp_o(overcurrent_protection_i));

  always #25 sys_clk_i = ~sys_clk_i;
  // ==========
  // Tasks
  // ==========
  task cyc(int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // Button pin passes four flops, so hold it well past that
  task press;
    onoff_btn_i = 1'b1;
    cyc(6);
    onoff_btn_i = 1'b0;
    cyc(6);
  endtask
  task note(int s, logic [15:0] v);
    q.push_back('{s, v});
  endtask
  task chk(logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // Monitor and watchdog
  // ==========
  // Look just after the falling edge, once every note of that edge is queued
  always @(negedge sys_clk_i) begin
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      chk(n.s < 6 ? {15'h0000, flags[n.s]} : n.s == 6 ? set_u_o : n.s == 7 ? {15'h0000, sink_en_o} :
        n.s == 8 ? set_p_o : sink_current_setpoint_o, n.v);
    end
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  // ==========
  // Scenarios
  // ==========
  initial begin
    {nrst_i, resist_mode_i, cfg_enter_i, func_sel_i, target_cur_i, cfg_exit_i, gen_quit_i} = '0;
    {start_touch_i, stop_touch_i, onoff_btn_i, dev_alarm_i, overpower_protection_i} = '0;
    {event_alarm_i, alarm_ack_i, sink_cur_wr_i, trip_req, func_kind_i, sink_cur_i} = '0;
    amp_i = 16'h0800 | 16'($random(seed) & 'h7ff);
    offset_i = 16'h1000 | 16'($random(seed) & 'hfff);
    freq_i = 14'($random(seed));
    static_u_i = 16'($random(seed) & 'h3fff);
    static_i_i = 16'h0400;
    static_p_i = 16'h7000;
    {t1_i, t2_i, t3_i, t4_i} = {4{29'h0000002}};
    cyc(2);
    nrst_i = 1'b1;
    resist_mode_i = 1'b1;
    pulse(cfg_enter_i);
    note(4, 16'h0001);
    resist_mode_i = 1'b0;
    cyc(1);
    pulse(cfg_enter_i);
    note(3, 16'h0001);
    // Every kind once; rectangle selected last, voltage target
    for (int k = 0; k < 4; k++) begin
      sink_cur_i = 16'h0001 + 16'($random(seed) & 'hfff);
      pulse(sink_cur_wr_i);
      note(9, sink_cur_i);
      func_kind_i = 2'((k + 3) % 4);
      pulse(func_sel_i);
      note(9, 16'h0000);
    end
    pulse(cfg_exit_i);
    cyc(1);
    note(0, 16'h0001);
    note(6, static_u_i);
    note(8, static_p_i);
    pulse(cfg_enter_i);
    note(3, 16'h0000);
    pulse(start_touch_i);
    note(1, 16'h0001);
    cyc(4);
    repeat (16000) begin
      @(negedge sys_clk_i);
      top += int'(set_u_o === amp_i + offset_i);
      bas += int'(set_u_o === offset_i);
      bad += int'(set_i_o !== static_i_i);
    end
    chk({15'h0000, top > 6000 && bas > 6000}, 16'h0001);
    chk(16'(top + bas), 16'd16000);
    chk(16'(bad), 16'h0000);
    amp_i = amp_i + 16'h0010;
    cyc(4100);
    note(1, 16'h0001);
    pulse(stop_touch_i);
    cyc(1);
    note(1, 16'h0000);
    note(0, 16'h0001);
    note(6, static_u_i);
    // Static voltage above the wave peak makes sink legal
    static_u_i = 16'h7000;
    sink_cur_i = 16'h0040;
    pulse(sink_cur_wr_i);
    cyc(3);
    note(7, 16'h0001);
    press;
    note(0, 16'h0000);
    note(7, 16'h0000);
    press;
    note(1, 16'h0001);
    press;
    note(0, 16'h0000);
    note(1, 16'h0000);
    // Each trip source aborts a fresh run
    for (int k = 0; k < 4; k++) begin
      press;
      {trip_req, event_alarm_i, overpower_protection_i, dev_alarm_i} = 4'(1 << k);
      cyc(8);
      {trip_req, event_alarm_i, overpower_protection_i, dev_alarm_i} = 4'h0;
      cyc(6);
      note(0, 16'h0000);
      note(1, 16'h0000);
      note(5, 16'h0001);
      pulse(alarm_ack_i);
      note(5, 16'h0000);
    end
    pulse(gen_quit_i);
    note(2, 16'h0000);
    cyc(2);
    report_and_stop();
  end
endmodule // tb_waveform_function_sequencer

// file: test/wfs_sequencer_sva.sv
/* Port checker for wfs_sequencer: commands, alarms, setpoints.
   Assumes one clock domain; bound onto every sequencer. */
`timescale 1ns/1ns
module wfs_sequencer_sva (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic resist_mode_i,
  input wire logic cfg_enter_i,
  input wire logic func_sel_i,
  input wire logic cfg_exit_i,
  input wire logic start_touch_i,
  input wire logic stop_touch_i,
  input wire logic onoff_btn_i,
  input wire logic dev_alarm_i,
  input wire logic overpower_protection_i,
  input wire logic overcurrent_protection_i,
  input wire logic event_alarm_i,
  input wire logic [wfs_pkg::VAL_W-1:0] static_p_i,
  input wire logic dc_on_o,
  input wire logic [wfs_pkg::VAL_W-1:0] set_p_o,
  input wire logic [wfs_pkg::VAL_W-1:0] sink_current_setpoint_o,
  input wire logic sink_en_o,
  input wire logic cfg_active_o,
  input wire logic gen_view_o,
  input wire logic running_o,
  input wire logic cfg_refused_o,
  input wire logic alarm_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========
  // Helpers
  // ==========
  // Pins lag through synchronisers, so calm also needs them low
  wire logic trip = overpower_protection_i | overcurrent_protection_i | event_alarm_i;
  wire logic calm = !trip && !onoff_btn_i && !dev_alarm_i;
  sequence refuse_s;
    cfg_enter_i && resist_mode_i && !cfg_active_o;
  endsequence
  sequence stop_s;
    running_o && stop_touch_i && calm;
  endsequence
  // ==========
  // Assertions
  // ==========
  cfg_refuse_a: assert property (refuse_s |=> cfg_refused_o && !cfg_active_o)
    else $error("config entry not refused");
  cfg_dc_on_a: assert property (cfg_enter_i && dc_on_o |=> !cfg_active_o)
    else $error("config entered with output on");
  cfg_exit_a: assert property (cfg_active_o && cfg_exit_i && !trip |=> gen_view_o && dc_on_o)
    else $error("exit did not switch output on");
  sink_clear_a: assert property (cfg_active_o && func_sel_i |=> sink_current_setpoint_o == 16'h0000)
    else $error("sink current kept on select");
  touch_start_a: assert property (gen_view_o && !running_o && dc_on_o && start_touch_i && calm && !alarm_o |=> running_o)
    else $error("touch start ignored");
  touch_stop_a: assert property (stop_s |=> (!running_o && dc_on_o) [*2])
    else $error("touch stop wrong");
  trip_abort_a: assert property (trip |=> !dc_on_o && alarm_o && !running_o)
    else $error("trip did not abort");
  power_limit_a: assert property (running_o |-> set_p_o == $past(static_p_i))
    else $error("power limit not static");
  sink_block_a: assert property ((sink_current_setpoint_o == 16'h0000 || !dc_on_o) [*2] |-> !sink_en_o)
    else $error("sink enabled without current");
  run_hold_a: assert property ((running_o && calm && !stop_touch_i) [*6] |=> running_o)
    else $error("run stopped by itself");
endmodule // wfs_sequencer_sva

bind wfs_sequencer wfs_sequencer_sva chk (.*);

// file: test/wfs_stage_model.sv
/* Power stage stand-in: terminal voltage and overcurrent trip.
   Assumes the sequencer clock; the bench asks for trips. */
`timescale 1ns/1ns
module wfs_stage_model (
  input wire logic sys_clk_i,
  input wire logic dc_on_i,
  input wire logic [wfs_pkg::VAL_W-1:0] set_u_i,
  input wire logic trip_req_i,
  output logic [wfs_pkg::VAL_W-1:0] ext_volt_o,
  output logic ocp_o
);
  // ==========
  // Terminal
  // ==========
  // Weak external source while off, so the reading never freezes
  always_ff @(posedge sys_clk_i) begin
    ext_volt_o <= dc_on_i ? set_u_i : 16'h0100;
    ocp_o <= trip_req_i & dc_on_i;
  end
endmodule // wfs_stage_model
